// ### hdl/trc_reset_config.sv
// Reset sequencer and reference clock configuration with an AXI4-Lite register file
module trc_reset_config
   import trc_pkg::*;
#(
   parameter int RESET_CYCLES = SOFT_RESET_CYCLES
) (
   // Clock and power-on reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   // AXI4-Lite write address and data
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   // AXI4-Lite write response
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [7:0]            s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   // SPI command pins
   input  wire logic                  spi_sck_i,
   input  wire logic                  spi_cs_n_i,
   input  wire logic                  spi_sdi_i,
   // Commands passed on to the rest of the transceiver
   output logic                       spi_cmd_valid_o,
   output logic [15:0]                spi_cmd_o,
   // Open-drain reset pin and supply glitch detector
   input  wire logic                  rst_pin_i,
   output logic                       rst_pin_o,
   output logic                       rst_pin_oe_o,
   input  wire logic                  supply_glitch_i,
   // Reset state and oscillator controls
   output logic                       reset_active_o,
   output logic [LOAD_CAP_W-1:0]      xtal_load_cap_o,
   output logic                       clkout_o
);

   localparam int         CNT_W    = $clog2(RESET_CYCLES + 1);
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   typedef enum logic {
      TRC_ST_RESET,
      TRC_ST_RUN
   } trc_state_type;

   trc_state_type         state;
   trc_state_type         next_state;
   logic [CNT_W-1:0]      cnt;
   logic [CNT_W-1:0]      next_cnt;
   trc_cause_type         cause;
   trc_cause_type         next_cause;

   logic                  glitch_reset_disable;
   logic                  clkout_en;
   logic [CLK_SEL_W-1:0]  clk_sel;
   logic                  sensitive;
   logic                  pin_low;
   logic                  cmd_valid;
   logic [15:0]           cmd_word;
   logic                  soft_req;

   logic [7:0]            aw_addr;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  wr_fire;

   if (RESET_CYCLES < 2) begin : g_bad_cycles
      $error("trc_reset_config: RESET_CYCLES must be at least 2");
   end

   // Register decode used by both the write and the read paths
   function automatic logic addr_mapped(input logic [7:0] addr);
      return addr == ADDR_FIFO_RST || addr == ADDR_CLK_LOAD || addr == ADDR_STATUS;
   endfunction

   // SPI command words
   trc_spi_cmd_rx #(
      .WORD_W       (16)
   ) u_spi_rx (
      .sys_clk_i    (sys_clk_i),
      .rst_n_i      (rst_n_i),
      .spi_sck_i    (spi_sck_i),
      .spi_cs_n_i   (spi_cs_n_i),
      .spi_sdi_i    (spi_sdi_i),
      .word_valid_o (cmd_valid),
      .word_o       (cmd_word)
   );

   // Clock output prescaler
   trc_clk_prescaler #(
      .REF_DIV   (REF_CYCLES)
   ) u_prescaler (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .en_i      (clkout_en),
      .sel_i     (clk_sel),
      .clk_o     (clkout_o)
   );

   // Trigger terms; the pin is only believed while we are not pulling it ourselves
   assign sensitive = !glitch_reset_disable;
   assign pin_low   = !rst_pin_i && !rst_pin_oe_o;
   assign soft_req  = cmd_valid && cmd_word == SOFT_RESET_CMD && sensitive;

   // Next reset state; pin wins over glitch, glitch over software command
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_cause = cause;
      case (state)
         TRC_ST_RESET: begin
            if (cnt == '0) begin
               next_state = TRC_ST_RUN;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         TRC_ST_RUN: begin
            if (pin_low || (supply_glitch_i && sensitive) || soft_req) begin
               next_state = TRC_ST_RESET;
               next_cnt   = CNT_W'(RESET_CYCLES - 1);
               if (pin_low) begin
                  next_cause = TRC_CAUSE_PIN;
               end else if (supply_glitch_i && sensitive) begin
                  next_cause = TRC_CAUSE_GLITCH;
               end else begin
                  next_cause = TRC_CAUSE_SOFT;
               end
            end
         end
         default: begin
            next_state = TRC_ST_RESET;
            next_cnt   = CNT_W'(RESET_CYCLES - 1);
         end
      endcase
   end

   // Reset sequencer; power-on holds the same interval after release
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state          <= TRC_ST_RESET;
         cnt            <= CNT_W'(RESET_CYCLES - 1);
         cause          <= TRC_CAUSE_POR;
         reset_active_o <= 1'b1;
         rst_pin_oe_o   <= 1'b1;
      end else begin
         state          <= next_state;
         cnt            <= next_cnt;
         cause          <= next_cause;
         reset_active_o <= next_state == TRC_ST_RESET;
         rst_pin_oe_o   <= next_state == TRC_ST_RESET;
      end
   end

   // Open drain: the pin is only ever pulled low, the pull-up makes the high
   always_ff @(posedge sys_clk_i) begin
      rst_pin_o <= 1'b0;
   end

   // Commands reach the transceiver only outside reset; reset words stop here
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         spi_cmd_valid_o <= 1'b0;
         spi_cmd_o       <= '0;
      end else begin
         spi_cmd_valid_o <= 1'b0;
         if (cmd_valid && state == TRC_ST_RUN && cmd_word != SOFT_RESET_CMD) begin
            spi_cmd_valid_o <= 1'b1;
            spi_cmd_o       <= cmd_word;
         end
      end
   end

   // Write channel: address and data taken in either order, answered once both are held
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OK;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(aw_addr) ? RESP_OK : RESP_ERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Control registers; reset holds them at their defaults and drops writes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || state == TRC_ST_RESET) begin
         glitch_reset_disable <= GLITCH_DIS_RESET;
         xtal_load_cap_o      <= LOAD_CAP_RESET;
         clkout_en            <= CLKOUT_EN_RESET;
         clk_sel              <= CLK_SEL_RESET;
      end else if (wr_fire && w_strb[0]) begin
         if (aw_addr == ADDR_FIFO_RST) begin
            glitch_reset_disable <= w_data[GLITCH_DIS_BIT];
         end
         if (aw_addr == ADDR_CLK_LOAD) begin
            xtal_load_cap_o <= w_data[LOAD_CAP_LSB +: LOAD_CAP_W];
            clkout_en       <= w_data[CLKOUT_EN_BIT];
            clk_sel         <= w_data[CLK_SEL_LSB +: CLK_SEL_W];
         end
      end
   end

   // Read channel: data and valid together one edge after the address is taken
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OK;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= addr_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
            s_axi_rdata   <= '0;
            case (s_axi_araddr)
               ADDR_FIFO_RST: begin
                  s_axi_rdata[GLITCH_DIS_BIT] <= glitch_reset_disable;
               end
               ADDR_CLK_LOAD: begin
                  s_axi_rdata[LOAD_CAP_LSB +: LOAD_CAP_W] <= xtal_load_cap_o;
                  s_axi_rdata[CLKOUT_EN_BIT]              <= clkout_en;
                  s_axi_rdata[CLK_SEL_LSB +: CLK_SEL_W]   <= clk_sel;
               end
               ADDR_STATUS: begin
                  s_axi_rdata[ST_RESET_BIT]                   <= reset_active_o;
                  s_axi_rdata[ST_SENS_BIT]                    <= sensitive;
                  s_axi_rdata[ST_CAUSE_LSB +: 2]              <= cause;
                  s_axi_rdata[ST_LOADCAP_LSB +: ST_LOADCAP_W] <=
                     LOAD_CAP_BASE + ST_LOADCAP_W'(xtal_load_cap_o);
               end
               default: begin
                  s_axi_rdata <= '0;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Length of the current reset interval, for checking only
   logic [CNT_W:0] res_len;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !reset_active_o) begin
         res_len <= '0;
      end else begin
         res_len <= res_len + 1'b1;
      end
   end

   chk_por_defaults: assert property (@(posedge sys_clk_i)
      !rst_n_i |=> reset_active_o && !glitch_reset_disable && xtal_load_cap_o == LOAD_CAP_RESET)
      else $error("power-on did not restore defaults");

   chk_spi_blocked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      spi_cmd_valid_o |-> $past(state) == TRC_ST_RUN && $past(cmd_valid))
      else $error("command forwarded during reset");

   chk_soft_reset_taken: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      state == TRC_ST_RUN && cmd_valid && cmd_word == SOFT_RESET_CMD && sensitive
      |=> reset_active_o ##1 reset_active_o)
      else $error("software reset not taken in sensitive mode");

   chk_soft_reset_dropped: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      state == TRC_ST_RUN && cmd_valid && cmd_word == SOFT_RESET_CMD && !sensitive && !pin_low
      |=> !reset_active_o && !spi_cmd_valid_o)
      else $error("software reset acted in normal mode");

   chk_reset_interval: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $fell(reset_active_o) |-> res_len == (CNT_W+1)'(RESET_CYCLES))
      else $error("reset interval has wrong length");

   chk_sens_restored: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $fell(reset_active_o) |-> !glitch_reset_disable && clk_sel == CLK_SEL_RESET)
      else $error("registers not reloaded by reset");

   chk_glitch_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      state == TRC_ST_RUN && supply_glitch_i && !pin_low
      |=> reset_active_o == $past(sensitive))
      else $error("glitch response does not follow mode");

   chk_pin_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      state == TRC_ST_RUN && pin_low |=> reset_active_o && cause == TRC_CAUSE_PIN)
      else $error("reset pin ignored");

   chk_pin_open_drain: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !rst_pin_o && (rst_pin_oe_o == reset_active_o))
      else $error("reset pin driven high or out of step");

   chk_load_map: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(s_axi_rvalid) && $past(s_axi_araddr) == ADDR_STATUS
      |-> s_axi_rdata[ST_LOADCAP_LSB +: ST_LOADCAP_W] == LOAD_CAP_BASE + ST_LOADCAP_W'($past(xtal_load_cap_o)))
      else $error("load capacitance code mapped wrongly");

   cov_soft_reset: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(reset_active_o) && cause == TRC_CAUSE_SOFT);

   cov_pin_reset: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(reset_active_o) && cause == TRC_CAUSE_PIN);

   cov_glitch_reset: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $rose(reset_active_o) && cause == TRC_CAUSE_GLITCH);

   cov_soft_ignored: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      state == TRC_ST_RUN && cmd_valid && cmd_word == SOFT_RESET_CMD && !sensitive);

endmodule

// ### hdl/trc_pkg.sv
// Shared constants, types and decode functions of the reset and clock configuration block
package trc_pkg;

   // Clock rates and the derived reference division
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int REF_CLK_HZ = 10_000_000;
   localparam int REF_CYCLES = SYS_CLK_HZ / REF_CLK_HZ;

   // Reset interval, printed in milliseconds, rounded up to whole cycles
   localparam real SOFT_RESET_MS     = 0.25;
   localparam int  SOFT_RESET_CYCLES = int'($ceil(SOFT_RESET_MS * SYS_CLK_HZ / 1000.0));

   // Register byte offsets on the bus
   localparam logic [7:0] ADDR_FIFO_RST = 8'h00;
   localparam logic [7:0] ADDR_CLK_LOAD = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;

   // fifo_and_reset_config fields
   localparam int GLITCH_DIS_BIT = 0;

   // clock_and_load_select fields
   localparam int LOAD_CAP_LSB  = 0;
   localparam int LOAD_CAP_W    = 4;
   localparam int CLKOUT_EN_BIT = 4;
   localparam int CLK_SEL_LSB   = 5;
   localparam int CLK_SEL_W     = 3;

   // status_word fields
   localparam int ST_RESET_BIT   = 0;
   localparam int ST_SENS_BIT    = 1;
   localparam int ST_CAUSE_LSB   = 2;
   localparam int ST_LOADCAP_LSB = 8;
   localparam int ST_LOADCAP_W   = 6; // 16 pF is 32 half picofarads, one bit past a 5-bit field

   // Reset values
   localparam logic                  GLITCH_DIS_RESET = 1'b0;
   localparam logic [LOAD_CAP_W-1:0] LOAD_CAP_RESET   = 4'h0;
   localparam logic                  CLKOUT_EN_RESET  = 1'b1;
   localparam logic [CLK_SEL_W-1:0]  CLK_SEL_RESET    = 3'h0;

   // Software reset command word and load capacitance base in half picofarads
   localparam logic [15:0]             SOFT_RESET_CMD = 16'hFE00;
   localparam logic [ST_LOADCAP_W-1:0] LOAD_CAP_BASE  = 6'h11;

   // Cause of the most recent reset
   typedef enum logic [1:0] {
      TRC_CAUSE_POR,
      TRC_CAUSE_GLITCH,
      TRC_CAUSE_SOFT,
      TRC_CAUSE_PIN
   } trc_cause_type;

   // Divisor of the reference for each clock output selection
   function automatic logic [3:0] trc_clk_div(input logic [CLK_SEL_W-1:0] sel);
      logic [3:0] div;
      div = 4'hA;
      case (sel)
         3'h0:    div = 4'hA;
         3'h1:    div = 4'h8;
         3'h2:    div = 4'h6;
         3'h3:    div = 4'h5;
         3'h4:    div = 4'h4;
         3'h5:    div = 4'h3;
         3'h6:    div = 4'h2;
         default: div = 4'h1;
      endcase
      return div;
   endfunction

endpackage

// ### hdl/trc_spi_cmd_rx.sv
// Serial command receiver: collects 16-bit command words from the SPI pins
module trc_spi_cmd_rx
   import trc_pkg::*;
#(
   parameter int WORD_W = 16
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   // SPI pins, sampled on the system clock
   input  wire logic              spi_sck_i,
   input  wire logic              spi_cs_n_i,
   input  wire logic              spi_sdi_i,
   // Received word
   output logic                   word_valid_o,
   output logic [WORD_W-1:0]      word_o
);

   localparam int CNT_W = $clog2(WORD_W);

   logic              sck_prev;
   logic [WORD_W-1:0] shift;
   logic [CNT_W-1:0]  bit_cnt;
   logic              sck_rise;

   if (WORD_W < 2) begin : g_bad_width
      $error("trc_spi_cmd_rx: WORD_W must be at least 2");
   end

   // Serial clock edge seen through the previous sample
   assign sck_rise = spi_sck_i && !sck_prev && !spi_cs_n_i;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sck_prev <= 1'b0;
      end else begin
         sck_prev <= spi_sck_i;
      end
   end

   // Shift in MSB first; chip select high aborts a partial word
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         shift        <= '0;
         bit_cnt      <= '0;
         word_valid_o <= 1'b0;
         word_o       <= '0;
      end else begin
         word_valid_o <= 1'b0;
         if (spi_cs_n_i) begin
            bit_cnt <= '0;
         end else if (sck_rise) begin
            shift <= {shift[WORD_W-2:0], spi_sdi_i};
            if (bit_cnt == CNT_W'(WORD_W - 1)) begin
               bit_cnt      <= '0;
               word_o       <= {shift[WORD_W-2:0], spi_sdi_i};
               word_valid_o <= 1'b1;
            end else begin
               bit_cnt <= bit_cnt + 1'b1;
            end
         end
      end
   end

endmodule

// ### hdl/trc_clk_prescaler.sv
// Clock output prescaler: divides the reference rate by one of eight divisors
module trc_clk_prescaler
   import trc_pkg::*;
#(
   parameter int REF_DIV = REF_CYCLES
) (
   // Clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_n_i,
   // Control
   input  wire logic                 en_i,
   input  wire logic [CLK_SEL_W-1:0] sel_i,
   // Divided clock
   output logic                      clk_o
);

   logic [7:0] cnt;
   logic [7:0] half_m1;

   if (REF_DIV < 2 || REF_DIV % 2 != 0 || REF_DIV > 24) begin : g_bad_div
      $error("trc_clk_prescaler: REF_DIV must be even, 2 to 24");
   end

   // Half period in system cycles, minus one
   assign half_m1 = 8'((REF_DIV / 2) * trc_clk_div(sel_i) - 1);

   // Toggle on reaching half a period; >= keeps a shrunken selection from overrunning
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !en_i) begin
         cnt   <= '0;
         clk_o <= 1'b0;
      end else if (cnt >= half_m1) begin
         cnt   <= '0;
         clk_o <= !clk_o;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   chk_clk_no_early: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      en_i && $past(en_i) && $past(cnt) < $past(half_m1) |-> $stable(clk_o))
      else $error("clock output toggled before half period");

   chk_clk_half_period: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      en_i && $past(en_i) && $changed(clk_o) |-> $past(cnt) >= $past(half_m1))
      else $error("clock output toggled at wrong count");

endmodule

// ### test/trc_host_model.sv
// Host controller model: drives the SPI command pins and pulls the reset line
module trc_host_model (
   // Clock
   input  wire logic sys_clk_i,
   // Pins towards the device
   output logic      spi_sck_o,
   output logic      spi_cs_n_o,
   output logic      spi_sdi_o,
   output logic      pin_low_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle pins: serial clock rests low outside frames
   initial begin
      spi_sck_o  = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_sdi_o  = 1'b1;
      pin_low_o  = 1'b0;
   end

   // One 16-bit word, MSB first, each clock level held two cycles
   task automatic send(input logic [15:0] w);
      @(posedge sys_clk_i);
      spi_cs_n_o <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi_o <= w[i];
         spi_sck_o <= 1'b0;
         repeat (2) @(posedge sys_clk_i);
         spi_sck_o <= 1'b1;
         repeat (2) @(posedge sys_clk_i);
      end
      spi_sck_o  <= 1'b0;
      spi_cs_n_o <= 1'b1;
      spi_sdi_o  <= ~w[0]; // Released line must not show a stale bit
   endtask

   // Pull the open-drain reset line low for one cycle
   task automatic pulse_pin();
      @(posedge sys_clk_i);
      pin_low_o <= 1'b1;
      @(posedge sys_clk_i);
      pin_low_o <= 1'b0;
   endtask
endmodule

// ### test/tb_top.sv
// Testbench of the reset sequencer and clock configuration block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RC = 20;
   logic        clk, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, glitch = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic [1:0]  rr, br;
   wire logic   awready, wready, bvalid, arready, rvalid, sck, cs_n, sdi, pin_low, cmd_valid, pin_o, pin_oe;
   wire logic   rst_act, clkout;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [15:0] cmd;
   wire logic [3:0]  cap;
   int          n_fail = 0, n_checks = 0, n_cmd = 0, n_rst = 0, n_low = 0;
   // Open-drain wire with pull-up
   wire logic   pin = (pin_oe ? pin_o : 1'b1) & ~pin_low;

   trc_reset_config #(.RESET_CYCLES(RC)) DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
      .spi_sdi_i(sdi), .spi_cmd_valid_o(cmd_valid), .spi_cmd_o(cmd), .rst_pin_i(pin), .rst_pin_o(pin_o),
      .rst_pin_oe_o(pin_oe), .supply_glitch_i(glitch), .reset_active_o(rst_act), .xtal_load_cap_o(cap),
      .clkout_o(clkout));
   trc_host_model host (.sys_clk_i(clk), .spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_sdi_o(sdi), .pin_low_o(pin_low));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Count forwarded commands and reset cycles, so pulses inside a task are not missed
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) n_cmd++;
      if (rst_act === 1'b1) n_rst++;
      if (pin === 1'b0) n_low++;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      awaddr  <= a;
      wdata   <= d;
      bready  <= 1'b1;
      // No cycle count assumed: only the watchdog ends a write that is never answered
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         br = bresp;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         rd = rdata;
         rr = rresp;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
   // Reset pulse on the supply glitch input, then time for the reset to finish
   task automatic glitch_pulse(output int b);
      b = n_rst;
      @(posedge clk);
      glitch <= 1'b1;
      @(posedge clk);
      glitch <= 1'b0;
      repeat (40) @(posedge clk);
   endtask
   task automatic span(output int n);
      logic v;
      v = clkout;
      n = 0;
      while (clkout === v && n < 50) begin
         @(posedge clk);
         n++;
      end
   endtask

   task automatic t_defaults();
      axi_rd(8'h08);
      chk("status", 32'h1102, rd);
      axi_rd(8'h04);
      chk("clk_load", 32'h10, rd);
      axi_rd(8'h0C);
      chk("unmapped", 32'h2, {30'h0, rr});
      axi_wr(8'h0C, 32'h1);
      chk("wr_unmapped", 32'h2, {30'h0, br});
   endtask
   task automatic t_loadcap();
      for (int c = 0; c < 16; c += 5) begin
         axi_wr(8'h04, 32'h10 | c);
         axi_rd(8'h08);
         chk("load_code", c, {28'h0, cap});
         chk("load_half_pf", ((17 + c) << 8) | 2, rd);
      end
   endtask
   task automatic t_soft();
      int b = n_rst;
      int m = n_cmd;
      int p = n_low;
      host.send(16'h1234);
      repeat (4) @(posedge clk);
      chk("cmd_word", 32'h1234, {16'h0, cmd});
      host.send(16'hFE00);
      repeat (40) @(posedge clk);
      chk("soft_len", RC, n_rst - b);
      chk("cmd_count", m + 1, n_cmd);
      chk("pin_held", RC, n_low - p);
      axi_rd(8'h04);
      chk("soft_restore", 32'h10, rd);
      axi_rd(8'h08);
      chk("soft_cause", 32'h110A, rd);
   endtask
   task automatic t_normal();
      int b;
      axi_wr(8'h00, 32'h1);
      chk("wr_resp", 32'h0, {30'h0, br});
      axi_rd(8'h08);
      chk("normal_mode", 32'h1108, rd);
      host.send(16'hFE00);
      glitch_pulse(b);
      chk("no_reset", b, n_rst);
      host.pulse_pin();
      repeat (40) @(posedge clk);
      chk("pin_len", RC, n_rst - b);
      axi_rd(8'h08);
      chk("pin_cause", 32'h110E, rd);
      glitch_pulse(b);
      chk("glitch_len", RC, n_rst - b);
   endtask
   task automatic t_clk();
      int div[8] = '{10, 8, 6, 5, 4, 3, 2, 1};
      int n;
      for (int s = 0; s < 8; s++) begin
         axi_wr(8'h04, 32'h10 | (s << 5));
         repeat (3) span(n);
         chk("half_period", 2 * div[s], n);
      end
      // Output disabled: the pin must rest low and never toggle
      axi_wr(8'h04, 32'h0);
      repeat (2) @(posedge clk);
      span(n);
      chk("clkout_off", 50, n);
      chk("clkout_low", 32'h0, {31'h0, clkout});
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      t_defaults();
      t_loadcap();
      t_soft();
      t_normal();
      t_clk();
      final_report();
   end
   // Watchdog: the tests need well under 5000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule
